// ---- hw/aefs_pkg.sv ----
/*
  package of the actuator error flag supervisor: object indices, bit
  positions, timing figures and carrier structs.
  assumes a single 125 MHz device clock.
*/
package aefs_pkg;
  // =====================================================
  // object indices and frame placement
  localparam logic [15:0] ERR_FLAGS_INDEX = 16'h2205;
  localparam logic [15:0] TIMEOUT_INDEX = 16'h2005;
  localparam int FEEDBACK_ERR_BYTE = 7;
  localparam logic [7:0] ERR_FLAGS_RESET = 8'h00;
  // =====================================================
  // error and enable bit positions
  localparam int BIT_PARAM = 0;
  localparam int BIT_OVERLOAD = 1;
  localparam int BIT_VOLTAGE = 2;
  localparam int BIT_TEMP = 3;
  localparam int BIT_BACKDRIVE = 4;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_FATAL = 6;
  localparam int BIT_MEMORY = 7;
  localparam int BIT_ENABLE = 0;
  // =====================================================
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int OVERLOAD_MS = 15;
  localparam int GRACE_S = 10;
  localparam int TIMEOUT_DEFAULT_MS = 5000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int OVERLOAD_CYCLES = OVERLOAD_MS * CYCLES_PER_MS;
  localparam longint GRACE_CYCLES = longint'(GRACE_S) * longint'(CLK_HZ);
  localparam logic [15:0] TIMEOUT_DEFAULT = 16'(TIMEOUT_DEFAULT_MS);
  // =====================================================
  // carriers
  typedef struct packed {
    logic param_bad;
    logic over_current;
    logic volt_bad;
    logic temp_bad;
    logic uncommanded_move;
    logic no_motion;
    logic mem_corrupt;
  } aefs_cond_t;
  typedef struct packed {
    logic valid;
    logic [7:0] control;
  } aefs_cmd_t;
endpackage : aefs_pkg

// ---- hw/aefs_supervisor.sv ----
/*
  actuator error flag supervisor: builds the error byte and gates motion.
  assumes conditions and command strobes are synchronous to sys_clk and
  that the ms tick counters are derived here from the clock.
*/
// Function
// - keep an eight-bit error status byte, one fault per bit
// - out-of-range command value sets bit 0 and blocks all motion
// - current above limit for 15 ms during motion sets bit 1
// - after overload, no new motion until enable cleared then set again
// - voltage out of range sets bit 2; running motion lasts 10 s max
// - temperature out of range sets bit 3; running motion lasts 10 s max
// - uncommanded tube movement sets bit 4
// - no command within timeout (default 5000 ms) sets bit 5
// - after timeout, motion blocked until enable cleared
// - motor driven with no resulting motion sets fatal bit 6
// - corrupted internal memory sets bit 7
// - command control bit 0 is motion enable; low means no motion
// - error byte reported as byte 7 of the feedback frame
`timescale 1ns/1ps
module aefs_supervisor #(
  parameter int OVERLOAD_CNT = aefs_pkg::OVERLOAD_CYCLES,
  parameter longint GRACE_CNT = aefs_pkg::GRACE_CYCLES,
  parameter int MS_CNT = aefs_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // command from host
  input wire aefs_pkg::aefs_cmd_t cmd,
  input wire logic [15:0] timeout_ms,
  // fault conditions and motion request
  input wire aefs_pkg::aefs_cond_t cond,
  input wire logic motion_request,
  // results
  output logic motion_allow,
  output logic [7:0] error_flags,
  output logic [63:0] feedback_frame_mask,
  output logic [7:0] feedback_err_byte
);
  import aefs_pkg::*;

  logic enable_bit;
  logic [7:0] next_error_flags;
  logic moving, next_moving;
  logic rearm_wait, next_rearm_wait;
  logic [31:0] over_cnt, next_over_cnt;
  logic [63:0] grace_cnt, next_grace_cnt;
  logic [31:0] ms_cnt, next_ms_cnt;
  logic [15:0] to_cnt, next_to_cnt;
  logic [15:0] to_limit;
  logic env_bad;
  logic start_ok;

  assign enable_bit = cmd.control[BIT_ENABLE];
  assign to_limit = (timeout_ms == 16'h0000) ? TIMEOUT_DEFAULT : timeout_ms;
  assign env_bad = error_flags[BIT_VOLTAGE] | error_flags[BIT_TEMP];

  // =====================================================
  // motion gating
  // enable gates start, param blocks all
  // fatal also refuses a start, else the sticky flag would toggle motion every cycle
  assign start_ok = enable_bit && !rearm_wait && !env_bad && !error_flags[BIT_PARAM]
                    && !error_flags[BIT_TIMEOUT] && !error_flags[BIT_OVERLOAD]
                    && !error_flags[BIT_FATAL];

  always_comb begin
    next_moving = moving;
    next_grace_cnt = grace_cnt;
    next_rearm_wait = rearm_wait;
    // re-arm needs enable low then high
    if (error_flags[BIT_OVERLOAD]) begin
      next_rearm_wait = 1'b1;
    end
    if (rearm_wait && !enable_bit) begin
      next_rearm_wait = 1'b0;
    end
    if (!moving) begin
      next_grace_cnt = 64'h0;
      if (motion_request && start_ok && !next_rearm_wait) begin
        next_moving = 1'b1;
      end
    end else begin
      // running motion may finish within grace time
      if (env_bad) begin
        next_grace_cnt = grace_cnt + 64'h1;
      end
      if (!motion_request || !enable_bit || error_flags[BIT_PARAM]
          || next_error_flags[BIT_OVERLOAD]
          || next_error_flags[BIT_TIMEOUT] || next_error_flags[BIT_FATAL]
          || (env_bad && grace_cnt >= 64'(GRACE_CNT - 1))) begin
        next_moving = 1'b0;
      end
    end
  end

  assign motion_allow = moving;

  // =====================================================
  // error byte
  always_comb begin
    next_error_flags = error_flags;
    next_over_cnt = 32'h0;
    next_ms_cnt = ms_cnt;
    next_to_cnt = to_cnt;
    if (cond.param_bad) begin
      next_error_flags[BIT_PARAM] = 1'b1;
    end
    if (moving && cond.over_current) begin
      next_over_cnt = over_cnt + 32'h1;
      if (over_cnt >= 32'(OVERLOAD_CNT - 1)) begin
        next_error_flags[BIT_OVERLOAD] = 1'b1;
      end
    end
    next_error_flags[BIT_VOLTAGE] = cond.volt_bad;
    next_error_flags[BIT_TEMP] = cond.temp_bad;
    if (cond.uncommanded_move && !moving) begin
      next_error_flags[BIT_BACKDRIVE] = 1'b1;
    end
    if (cmd.valid) begin
      next_ms_cnt = 32'h0;
      next_to_cnt = 16'h0;
    end else if (ms_cnt >= 32'(MS_CNT - 1)) begin
      next_ms_cnt = 32'h0;
      if (to_cnt >= to_limit - 16'h1) begin
        next_error_flags[BIT_TIMEOUT] = 1'b1;
      end else begin
        next_to_cnt = to_cnt + 16'h1;
      end
    end else begin
      next_ms_cnt = ms_cnt + 32'h1;
    end
    if (moving && cond.no_motion) begin
      next_error_flags[BIT_FATAL] = 1'b1;
    end
    if (cond.mem_corrupt) begin
      next_error_flags[BIT_MEMORY] = 1'b1;
    end
    // enable low clears the overload, timeout and backdrive latches; a new event in the same cycle wins
    if (cmd.valid && !enable_bit) begin
      if (!(moving && cond.over_current && over_cnt >= 32'(OVERLOAD_CNT - 1))) begin
        next_error_flags[BIT_OVERLOAD] = 1'b0;
      end
      next_error_flags[BIT_TIMEOUT] = 1'b0;
      next_error_flags[BIT_BACKDRIVE] = cond.uncommanded_move && !moving;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_flags <= ERR_FLAGS_RESET;
      moving <= 1'b0;
      rearm_wait <= 1'b0;
      over_cnt <= 32'h0;
      grace_cnt <= 64'h0;
      ms_cnt <= 32'h0;
      to_cnt <= 16'h0;
    end else begin
      error_flags <= next_error_flags;
      moving <= next_moving;
      rearm_wait <= next_rearm_wait;
      over_cnt <= next_over_cnt;
      grace_cnt <= next_grace_cnt;
      ms_cnt <= next_ms_cnt;
      to_cnt <= next_to_cnt;
    end
  end

  // =====================================================
  // feedback byte
  // error byte in byte 7
  assign feedback_err_byte = error_flags;
  assign feedback_frame_mask = {error_flags, 56'h0};

  // =====================================================
  // checks
  param_blocks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_flags[BIT_PARAM] |=> !moving)
    else $error("motion while parameter error set");
  env_blocks_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!moving && env_bad) |=> !moving)
    else $error("motion started with env error");
  timeout_blocks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_flags[BIT_TIMEOUT] |=> !moving)
    else $error("motion during timeout");
  volt_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_flags[BIT_VOLTAGE] == $past(cond.volt_bad))
    else $error("voltage flag not following");
  fatal_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (moving && cond.no_motion) |=> error_flags[BIT_FATAL])
    else $error("fatal not set");
  mem_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cond.mem_corrupt |=> error_flags[BIT_MEMORY])
    else $error("memory error not set");
  enable_low_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enable_bit |=> !moving)
    else $error("motion with enable low");
  overload_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(error_flags[BIT_OVERLOAD]) |-> !moving)
    else $error("motion after overload");
  byte_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    feedback_frame_mask[63:56] == error_flags)
    else $error("feedback byte wrong");
  temp_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_flags[BIT_TEMP] == $past(cond.temp_bad))
    else $error("temperature flag not following");
  overload_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (moving && cond.over_current && over_cnt >= 32'(OVERLOAD_CNT - 1)) |=> error_flags[BIT_OVERLOAD])
    else $error("overload not set");
  backdrive_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cond.uncommanded_move && !moving) |=> error_flags[BIT_BACKDRIVE])
    else $error("backdrive not set");
  fatal_blocks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_flags[BIT_FATAL] |=> !moving)
    else $error("motion after fatal error");
  overload_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (error_flags[BIT_OVERLOAD] && !(cmd.valid && !enable_bit)) |=> error_flags[BIT_OVERLOAD])
    else $error("overload flag dropped early");
endmodule : aefs_supervisor

// ---- sim/aefs_host_model.sv ----
/*
  host model: sends one-cycle command frames to the supervisor.
  assumes the bench calls send from a single thread.
*/
`timescale 1ns/1ps
module aefs_host_model (
  // clock
  input wire logic sys_clk,
  // command out
  output aefs_pkg::aefs_cmd_t cmd
);
  import aefs_pkg::*;
  initial cmd = '0;
  // ==============================================
  // command pulse, motion enable in control bit 0
  // valid dropped after one cycle, control byte held
  task automatic send(input logic [7:0] ctl);
    @(posedge sys_clk);
    cmd <= '{valid: 1'b1, control: ctl};
    @(posedge sys_clk);
    cmd.valid <= 1'b0;
  endtask : send
endmodule : aefs_host_model

// ---- sim/tb_top.sv ----
/*
  testbench of the error flag supervisor, scaled counts.
  assumes the host model drives cmd; the bench drives conditions.
*/
`timescale 1ns/1ps
module tb_top;
  import aefs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  aefs_cmd_t cmd;
  logic [15:0] timeout_ms = 16'h0014;
  aefs_cond_t cond = '0;
  logic motion_request = 1'b1;
  logic motion_allow;
  logic [7:0] error_flags;
  logic [63:0] feedback_frame_mask;
  logic [7:0] feedback_err_byte;
  int miscompares = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  aefs_host_model u_host (.sys_clk(sys_clk), .cmd(cmd));
  aefs_supervisor #(.OVERLOAD_CNT(20), .GRACE_CNT(50), .MS_CNT(10)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .timeout_ms(timeout_ms),
    .cond(cond), .motion_request(motion_request), .motion_allow(motion_allow),
    .error_flags(error_flags), .feedback_frame_mask(feedback_frame_mask),
    .feedback_err_byte(feedback_err_byte));
  // ==============================================
  // helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // ==============================================
  // scenarios
  task automatic t_start;
    tick(1);
    chk(error_flags, 8'h00);
    chk(motion_allow, 1'b0);
    u_host.send(8'h01);
    tick(3);
    chk(motion_allow, 1'b1);
  endtask : t_start
  task automatic t_overload;
    @(posedge sys_clk) cond.over_current <= 1'b1;
    tick(19);
    chk({error_flags, motion_allow}, 9'h001);
    tick(6);
    chk(error_flags, 8'h02);
    chk(motion_allow, 1'b0);
    @(posedge sys_clk) cond.over_current <= 1'b0;
    u_host.send(8'h01);
    tick(3);
    chk(motion_allow, 1'b0);
    u_host.send(8'h7e);
    tick(2);
    chk(error_flags, 8'h00);
    chk(motion_allow, 1'b0);
    u_host.send(8'h01);
    tick(3);
    chk(motion_allow, 1'b1);
  endtask : t_overload
  task automatic t_env;
    @(posedge sys_clk) cond.volt_bad <= 1'b1;
    tick(10);
    chk({error_flags, motion_allow}, 9'h009);
    tick(50);
    chk(motion_allow, 1'b0);
    @(posedge sys_clk) cond <= '{temp_bad: 1'b1, default: 1'b0};
    tick(2);
    chk(error_flags, 8'h08);
    @(posedge sys_clk) cond.temp_bad <= 1'b0;
    tick(2);
    chk(error_flags, 8'h00);
    chk(motion_allow, 1'b1);
  endtask : t_env
  task automatic t_request;
    @(posedge sys_clk) motion_request <= 1'b0;
    tick(2);
    chk(motion_allow, 1'b0);
    @(posedge sys_clk) motion_request <= 1'b1;
    tick(2);
    chk(motion_allow, 1'b1);
  endtask : t_request
  task automatic t_timeout;
    u_host.send(8'hfd);
    timeout_ms <= 16'h0005;
    tick(3);
    chk(motion_allow, 1'b1);
    tick(45);
    chk({error_flags, motion_allow}, 9'h001);
    tick(3);
    chk({error_flags, motion_allow}, 9'h040);
    u_host.send(8'h80);
    tick(2);
    chk(error_flags, 8'h00);
    @(posedge sys_clk) cond.uncommanded_move <= 1'b1;
    tick(2);
    chk(error_flags, 8'h10);
    @(posedge sys_clk) cond.uncommanded_move <= 1'b0;
    u_host.send(8'h00);
  endtask : t_timeout
  task automatic t_latched;
    u_host.send(8'h81);
    tick(3);
    @(posedge sys_clk) cond.no_motion <= 1'b1;
    tick(2);
    chk(error_flags[BIT_FATAL], 1'b1);
    @(posedge sys_clk) cond <= '{param_bad: 1'b1, mem_corrupt: 1'b1, default: 1'b0};
    @(posedge sys_clk) cond <= '0;
    tick(3);
    chk({feedback_err_byte, motion_allow}, 9'h182);
    chk(error_flags, 8'hc1);
    chk(feedback_frame_mask, {8'hc1, 56'h0});
  endtask : t_latched
  // ==============================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_start();
    t_overload();
    t_env();
    t_request();
    t_timeout();
    t_latched();
    close_out();
  end
  initial begin
    #40000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
